/* File: rtl/sync_phase_and_override_ctrl.sv */
// Behaviour
// - shift only a follower in synchronized motion
// - leader's own positions stay untouched
// - follower reference is leader position plus offset
// - correction speed rides on leader velocity
// - encoder leader uses follower velocity limit
// - retrigger restarts shift from present offset
// - retrigger with zero amount halts shift
// - no synchronized motion gives code 1130
// - wrong leader gives code 1131
// - shift outside INT range gives 1132
// - bad velocity gives code 1133
// - negative acc, dec, jerk give codes
// - inputs latched at trigger rising edge
// - live follow tracks inputs only while busy
// - level command follows inputs while enabled
// - target beyond stop point keeps direction
// - absolute override of speed, ramp, jerk
// - ratio 1.0 leaves values unchanged
// - speed ratio zero stops and holds axis at rest
// - ramp ratio zero applies speed at once
// - jerk ratio zero applies acceleration at once
// - mode bit selects ratio or absolute
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module sync_phase_and_override_ctrl
(
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire logic                    sync_running,
	input  wire logic [7:0]              sync_leader_id,
	input  wire logic                    leader_is_encoder,
	input  wire logic signed [31:0]      leader_pos,
	input  wire logic signed [31:0]      leader_vel,
	input  wire logic [31:0]             leader_vel_limit,
	input  wire logic [31:0]             follower_vel_limit,
	output logic signed [31:0]           leader_ref,
	output logic signed [31:0]           corr_speed,
	input  wire logic signed [31:0]      axis_pos,
	input  wire logic signed [31:0]      axis_vel,
	input  wire logic signed [31:0]      stop_dist,
	output logic signed [31:0]           target_cmd,
	output logic                         reverse_move,
	input  wire logic signed [31:0]      cur_speed,
	input  wire logic signed [31:0]      cur_ramp,
	input  wire logic signed [31:0]      cur_jerk,
	output logic signed [31:0]           speed_cmd,
	output logic signed [31:0]           ramp_cmd,
	output logic signed [31:0]           jerk_cmd,
	output logic                         rest_hold,
	output logic                         ramp_bypass,
	output logic                         jerk_bypass
);
	import motion_pkg::*;
	phase_if pif ();
	phase_gen u_gen (.hclk(hclk), .hresetn(hresetn), .pif(pif));

	logic [31:0]        ctrl_reg, vel_reg, acc_reg, dec_reg, jerk_reg;
	logic signed [31:0] shift_reg, target_reg, speed_reg, ramp_reg, jrat_reg;
	logic [7:0]         leader_sel_reg;
	logic               wr_pend_reg;
	logic [7:0]         wr_addr_reg;
	logic [31:0]        rdata_reg;
	logic               trig_d_reg, tgt_d_reg;
	logic signed [31:0] lat_amount_reg, base_reg;
	logic [31:0]        lat_vel_reg, lat_acc_reg;
	logic               done_reg, err_reg, pre_reg;
	logic [15:0]        fault_reg;
	logic [15:0]        chk_code;
	logic [31:0]        vlim;
	logic               take, trig_rise, tgt_rise, zero_retrig, lost;
	logic signed [31:0] covered, stop_point;
	logic signed [63:0] sp_prod, rp_prod, jp_prod;
	ovr_mode_t          mode;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;
	assign take = hsel & hready & (htrans == HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end
		else
		begin
			wr_pend_reg <= take & hwrite;
			wr_addr_reg <= haddr[ADDR_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg       <= CTRL_RST;
			shift_reg      <= '0;
			vel_reg        <= '0;
			acc_reg        <= '0;
			dec_reg        <= '0;
			jerk_reg       <= '0;
			leader_sel_reg <= '0;
			target_reg     <= '0;
			speed_reg      <= RATIO_ONE;
			ramp_reg       <= RATIO_ONE;
			jrat_reg       <= RATIO_ONE;
		end
		else if (wr_pend_reg)
		begin
			case (wr_addr_reg)
				CTRL_OFS:   ctrl_reg       <= hwdata;
				SHIFT_OFS:  shift_reg      <= hwdata;
				VEL_OFS:    vel_reg        <= hwdata;
				ACC_OFS:    acc_reg        <= hwdata;
				DEC_OFS:    dec_reg        <= hwdata;
				JERK_OFS:   jerk_reg       <= hwdata;
				LEADER_OFS: leader_sel_reg <= hwdata[7:0];
				TARGET_OFS: target_reg     <= hwdata;
				SPEED_OFS:  speed_reg      <= hwdata;
				RAMP_OFS:   ramp_reg       <= hwdata;
				JRAT_OFS:   jrat_reg       <= hwdata;
				default:    ;
			endcase
		end
	end

	// Read data is captured in the address phase so it stands for the whole data phase.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata_reg <= '0;
		else if (take & ~hwrite)
		begin
			case (haddr[ADDR_W-1:0])
				CTRL_OFS:    rdata_reg <= ctrl_reg;
				SHIFT_OFS:   rdata_reg <= shift_reg;
				VEL_OFS:     rdata_reg <= vel_reg;
				ACC_OFS:     rdata_reg <= acc_reg;
				DEC_OFS:     rdata_reg <= dec_reg;
				JERK_OFS:    rdata_reg <= jerk_reg;
				LEADER_OFS:  rdata_reg <= {24'h000000, leader_sel_reg};
				STATUS_OFS:  rdata_reg <= {fault_reg, 11'h000, pre_reg, pif.busy, err_reg, pif.busy, done_reg};
				COVERED_OFS: rdata_reg <= covered;
				REF_OFS:     rdata_reg <= leader_ref;
				TARGET_OFS:  rdata_reg <= target_reg;
				SPEED_OFS:   rdata_reg <= speed_reg;
				RAMP_OFS:    rdata_reg <= ramp_reg;
				JRAT_OFS:    rdata_reg <= jrat_reg;
				SPDCMD_OFS:  rdata_reg <= speed_cmd;
				default:     rdata_reg <= '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			trig_d_reg <= 1'b0;
			tgt_d_reg  <= 1'b0;
		end
		else
		begin
			trig_d_reg <= ctrl_reg[CTRL_TRIG_BIT];
			tgt_d_reg  <= ctrl_reg[CTRL_TGT_BIT];
		end
	end
	assign trig_rise = ctrl_reg[CTRL_TRIG_BIT] & ~trig_d_reg;
	assign tgt_rise  = ctrl_reg[CTRL_TGT_BIT] & ~tgt_d_reg;

	// Checks run in a fixed priority so that only one code is reported.
	always_comb
	begin
		chk_code = E_NONE;
		if (!sync_running)
			chk_code = E_NOSYNC;
		else if (leader_sel_reg != sync_leader_id)
			chk_code = E_LEADER;
		else if (shift_reg < INT_MIN || shift_reg > INT_MAX)
			chk_code = E_RANGE;
		else if (vel_reg[31] || vel_reg > leader_vel_limit)
			chk_code = E_VEL;
		else if (acc_reg[31])
			chk_code = E_ACC;
		else if (dec_reg[31])
			chk_code = E_DEC;
		else if (jerk_reg[31])
			chk_code = E_JERK;
	end

	assign zero_retrig = trig_rise & (chk_code == E_NONE) & pif.busy & (shift_reg == '0);
	assign lost = pif.busy & ~sync_running;
	assign pif.halt  = zero_retrig | lost;
	assign pif.start = trig_rise & (chk_code == E_NONE) & ~zero_retrig;

	// Inputs are taken at the edge; with live follow they keep tracking only while busy.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lat_amount_reg <= '0;
			lat_vel_reg    <= '0;
			lat_acc_reg    <= '0;
		end
		else if (pif.start || (ctrl_reg[CTRL_LIVE_BIT] && pif.busy))
		begin
			lat_amount_reg <= shift_reg;
			lat_vel_reg    <= vel_reg;
			lat_acc_reg    <= acc_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			base_reg <= '0;
		else if (pif.start)
			base_reg <= pif.offset;
	end

	assign vlim = leader_is_encoder ? follower_vel_limit : leader_vel_limit;
	assign pif.vmax   = (lat_vel_reg > vlim) ? vlim : lat_vel_reg;
	assign pif.acc    = lat_acc_reg;
	assign pif.target = base_reg + lat_amount_reg;
	assign covered    = pif.offset - base_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_reg  <= 1'b0;
			err_reg   <= 1'b0;
			fault_reg <= E_NONE;
			pre_reg   <= 1'b0;
		end
		else
		begin
			if (trig_rise)
			begin
				done_reg  <= 1'b0;
				pre_reg   <= 1'b0;
				err_reg   <= (chk_code != E_NONE);
				fault_reg <= chk_code;
			end
			if (pif.done)
				done_reg <= 1'b1;
			if (lost)
				pre_reg <= 1'b1;
		end
	end

	// The leader's own positions are only read here, never written back.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			leader_ref <= '0;
			corr_speed <= '0;
		end
		else
		begin
			leader_ref <= leader_pos + pif.offset;
			corr_speed <= leader_vel + pif.rate;
		end
	end
	assign stop_point = axis_vel[31] ? axis_pos - stop_dist : axis_pos + stop_dist;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			target_cmd   <= '0;
			reverse_move <= 1'b0;
		end
		else if (tgt_rise)
		begin
			target_cmd   <= target_reg;
			reverse_move <= axis_vel[31] ? (target_reg > stop_point) : (target_reg < stop_point);
		end
	end

	// The override is a level command: registers are followed directly while it is enabled.
	assign mode    = ovr_mode_t'(ctrl_reg[CTRL_MODE_BIT]);
	assign sp_prod = cur_speed * speed_reg;
	assign rp_prod = cur_ramp * ramp_reg;
	assign jp_prod = cur_jerk * jrat_reg;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			speed_cmd   <= '0;
			ramp_cmd    <= '0;
			jerk_cmd    <= '0;
			rest_hold   <= 1'b0;
			ramp_bypass <= 1'b0;
			jerk_bypass <= 1'b0;
		end
		else if (!ctrl_reg[CTRL_OVR_BIT])
		begin
			speed_cmd   <= cur_speed;
			ramp_cmd    <= cur_ramp;
			jerk_cmd    <= cur_jerk;
			rest_hold   <= 1'b0;
			ramp_bypass <= 1'b0;
			jerk_bypass <= 1'b0;
		end
		else if (mode == MODE_ABS)
		begin
			speed_cmd   <= speed_reg;
			ramp_cmd    <= ramp_reg;
			jerk_cmd    <= jrat_reg;
			rest_hold   <= 1'b0;
			ramp_bypass <= 1'b0;
			jerk_bypass <= 1'b0;
		end
		else
		begin
			speed_cmd   <= sp_prod[RATIO_FRAC+31:RATIO_FRAC];
			ramp_cmd    <= rp_prod[RATIO_FRAC+31:RATIO_FRAC];
			jerk_cmd    <= jp_prod[RATIO_FRAC+31:RATIO_FRAC];
			rest_hold   <= (speed_reg == '0);
			ramp_bypass <= (ramp_reg == '0);
			jerk_bypass <= (jrat_reg == '0);
		end
	end
	a_ref_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 leader_ref == $past(leader_pos) + $past(pif.offset))
		else $error("leader reference is not leader position plus offset");
	a_nosync_code: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_rise && !sync_running |=> err_reg && fault_reg == E_NOSYNC && !pif.busy)
		else $error("missing sync not rejected with 1130");
	a_leader_code: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_rise && sync_running && leader_sel_reg != sync_leader_id |=> fault_reg == E_LEADER)
		else $error("wrong leader not rejected with 1131");
	a_range_code: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_rise && sync_running && leader_sel_reg == sync_leader_id && shift_reg > INT_MAX
		|=> fault_reg == E_RANGE)
		else $error("out of range shift not rejected with 1132");
	a_zero_halts: assert property (@(posedge hclk) disable iff (!hresetn)
		zero_retrig |=> !pif.busy && $stable(pif.offset))
		else $error("zero retrigger did not halt the shift");
	a_edge_start: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(pif.busy) |-> $past(trig_rise) && !err_reg)
		else $error("shift started without a trigger edge");
	a_live_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!pif.start && !ctrl_reg[CTRL_LIVE_BIT] |=> $stable(lat_amount_reg))
		else $error("latched amount changed without a trigger edge");
	a_ratio_unity: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_reg[CTRL_OVR_BIT] && mode == MODE_RATIO && speed_reg == RATIO_ONE |=> speed_cmd == $past(cur_speed))
		else $error("unity ratio changed the speed");
	a_rest_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_reg[CTRL_OVR_BIT] && mode == MODE_RATIO && speed_reg == '0 |=> speed_cmd == '0 && rest_hold)
		else $error("zero speed ratio did not hold the axis");
	a_target_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		tgt_rise && !axis_vel[31] && target_reg >= stop_point |=> !reverse_move)
		else $error("reachable target reversed the move");
endmodule : sync_phase_and_override_ctrl

/* File: rtl/motion_pkg.sv */
package motion_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] SHIFT_OFS   = 8'h04;
	localparam logic [7:0] VEL_OFS     = 8'h08;
	localparam logic [7:0] ACC_OFS     = 8'h0c;
	localparam logic [7:0] DEC_OFS     = 8'h10;
	localparam logic [7:0] JERK_OFS    = 8'h14;
	localparam logic [7:0] LEADER_OFS  = 8'h18;
	localparam logic [7:0] STATUS_OFS  = 8'h1c;
	localparam logic [7:0] COVERED_OFS = 8'h20;
	localparam logic [7:0] REF_OFS     = 8'h24;
	localparam logic [7:0] TARGET_OFS  = 8'h28;
	localparam logic [7:0] SPEED_OFS   = 8'h2c;
	localparam logic [7:0] RAMP_OFS    = 8'h30;
	localparam logic [7:0] JRAT_OFS    = 8'h34;
	localparam logic [7:0] SPDCMD_OFS  = 8'h38;
	localparam int CTRL_TRIG_BIT = 0;
	localparam int CTRL_LIVE_BIT = 1;
	localparam int CTRL_OVR_BIT  = 2;
	localparam int CTRL_MODE_BIT = 3;
	localparam int CTRL_TGT_BIT  = 4;
	localparam int ST_DONE_BIT   = 0;
	localparam int ST_BUSY_BIT   = 1;
	localparam int ST_ERR_BIT    = 2;
	localparam int ST_ACT_BIT    = 3;
	localparam int ST_PRE_BIT    = 4;
	localparam int ST_CODE_LSB   = 16;
	localparam logic [15:0] E_NONE   = 16'h0000;
	localparam logic [15:0] E_NOSYNC = 16'h1130;
	localparam logic [15:0] E_LEADER = 16'h1131;
	localparam logic [15:0] E_RANGE  = 16'h1132;
	localparam logic [15:0] E_VEL    = 16'h1133;
	localparam logic [15:0] E_ACC    = 16'h1014;
	localparam logic [15:0] E_DEC    = 16'h1015;
	localparam logic [15:0] E_JERK   = 16'h1016;
	localparam logic signed [31:0] INT_MIN = -32'sh8000;
	localparam logic signed [31:0] INT_MAX = 32'sh7fff;
	localparam int RATIO_FRAC = 8;
	localparam logic [31:0] RATIO_ONE = 32'h0000_0100;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic {MODE_RATIO, MODE_ABS} ovr_mode_t;
	typedef enum logic {GEN_IDLE, GEN_MOVE} gen_state_t;
endpackage : motion_pkg

/* File: rtl/phase_if.sv */
`timescale 1ns/10ps
interface phase_if;
	logic               start;
	logic               halt;
	logic signed [31:0] target;
	logic        [31:0] vmax;
	logic        [31:0] acc;
	logic               busy;
	logic               done;
	logic signed [31:0] offset;
	logic signed [31:0] rate;
	modport ctrl (output start, halt, target, vmax, acc, input busy, done, offset, rate);
	modport gen (input start, halt, target, vmax, acc, output busy, done, offset, rate);
endinterface : phase_if

/* File: rtl/phase_gen.sv */
`timescale 1ns/10ps
module phase_gen
(
	input  wire logic hclk,
	input  wire logic hresetn,
	phase_if.gen      pif
);
	import motion_pkg::*;
	gen_state_t         state_reg;
	logic        [32:0] step_reg;
	logic        [32:0] step_next;
	logic signed [31:0] remain;
	logic        [31:0] mag;
	logic signed [31:0] offset_reg;
	logic               done_reg;

	assign remain = pif.target - offset_reg;
	assign mag = remain[31] ? 32'(-remain) : 32'(remain);
	// Zero acceleration jumps straight to the velocity limit.
	always_comb
	begin
		step_next = step_reg + {1'b0, pif.acc};
		if (pif.acc == '0 || step_next > {1'b0, pif.vmax})
			step_next = {1'b0, pif.vmax};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg  <= GEN_IDLE;
			step_reg   <= '0;
			offset_reg <= '0;
			done_reg   <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			if (pif.halt)
			begin
				state_reg <= GEN_IDLE;
				step_reg  <= '0;
			end
			else if (pif.start)
			begin
				state_reg <= GEN_MOVE;
				step_reg  <= '0;
			end
			else
			begin
				case (state_reg)
					GEN_MOVE:
					begin
						if ({1'b0, mag} <= step_next)
						begin
							offset_reg <= pif.target;
							state_reg  <= GEN_IDLE;
							step_reg   <= '0;
							done_reg   <= 1'b1;
						end
						else
						begin
							step_reg   <= step_next;
							offset_reg <= remain[31] ? offset_reg - step_next[31:0] : offset_reg + step_next[31:0];
						end
					end
					default: state_reg <= GEN_IDLE;
				endcase
			end
		end
	end

	assign pif.busy   = (state_reg == GEN_MOVE);
	assign pif.done   = done_reg;
	assign pif.offset = offset_reg;
	assign pif.rate   = remain[31] ? 32'(-step_reg[31:0]) : step_reg[31:0];
endmodule : phase_gen

/* File: test/axis_model.sv */
`timescale 1ns/10ps
module axis_model
#(
	parameter logic [7:0]  LEADER_ID = 8'h03,
	parameter logic [31:0] LEAD_LIM  = 32'h0000_0064,
	parameter logic [31:0] FOLL_LIM  = 32'h0000_0003
)
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               sync_on,
	input  wire logic               enc_on,
	input  wire logic signed [31:0] vel_set,
	output logic                    sync_running,
	output logic [7:0]              sync_leader_id,
	output logic                    leader_is_encoder,
	output logic signed [31:0]      leader_pos,
	output logic signed [31:0]      leader_vel,
	output logic [31:0]             leader_vel_limit,
	output logic [31:0]             follower_vel_limit
);
	// The leader integrates only its own velocity, so any follower offset stays invisible to it.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			leader_pos <= 32'sh0;
		else
			leader_pos <= leader_pos + vel_set;
	end
	assign sync_running       = sync_on;
	assign sync_leader_id     = LEADER_ID;
	assign leader_is_encoder  = enc_on;
	assign leader_vel         = vel_set;
	assign leader_vel_limit   = LEAD_LIM;
	assign follower_vel_limit = FOLL_LIM;
endmodule : axis_model

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
	import motion_pkg::*;
	localparam logic [7:0]  LID  = 8'h03;
	localparam logic [31:0] FLIM = 32'h0000_0003;
	logic               hclk;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic [31:0]        haddr = 32'h0;
	logic [1:0]         htrans = 2'h0;
	logic               hwrite = 1'b0;
	logic [2:0]         hsize = 3'h2;
	logic [31:0]        hwdata = 32'h0;
	logic               hreadyout, hresp, sync_running, leader_is_encoder;
	logic               reverse_move, rest_hold, ramp_bypass, jerk_bypass;
	logic [31:0]        hrdata, leader_vel_limit, follower_vel_limit, rdata;
	logic [7:0]         sync_leader_id;
	logic               sync_on = 1'b0;
	logic               enc_on = 1'b0;
	logic signed [31:0] vel_set = 32'sh4;
	logic signed [31:0] axis_pos = 32'sh0, axis_vel = 32'sh0, stop_dist = 32'sh0;
	logic signed [31:0] cur_speed = 32'sh0, cur_ramp = 32'sh0, cur_jerk = 32'sh0;
	logic signed [31:0] leader_pos, leader_vel, leader_ref, corr_speed, target_cmd;
	logic signed [31:0] speed_cmd, ramp_cmd, jerk_cmd, exp_off, amt, r0;
	logic [31:0]        ctrl_v = 32'h0;
	logic [15:0]        codes [8] = '{E_NOSYNC, E_LEADER, E_RANGE, E_VEL, E_ACC, E_DEC, E_JERK, E_VEL};
	int                 fail_count = 0;
	int                 n_compared = 0;
	int                 cyc = 0;

	axis_model #(.LEADER_ID(LID), .FOLL_LIM(FLIM)) partner (.hclk(hclk), .hresetn(hresetn), .sync_on(sync_on),
		.enc_on(enc_on), .vel_set(vel_set), .sync_running(sync_running), .sync_leader_id(sync_leader_id),
		.leader_is_encoder(leader_is_encoder), .leader_pos(leader_pos), .leader_vel(leader_vel),
		.leader_vel_limit(leader_vel_limit), .follower_vel_limit(follower_vel_limit));

	sync_phase_and_override_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sync_running(sync_running), .sync_leader_id(sync_leader_id),
		.leader_is_encoder(leader_is_encoder), .leader_pos(leader_pos), .leader_vel(leader_vel),
		.leader_vel_limit(leader_vel_limit), .follower_vel_limit(follower_vel_limit), .leader_ref(leader_ref),
		.corr_speed(corr_speed), .axis_pos(axis_pos), .axis_vel(axis_vel), .stop_dist(stop_dist),
		.target_cmd(target_cmd), .reverse_move(reverse_move), .cur_speed(cur_speed), .cur_ramp(cur_ramp),
		.cur_jerk(cur_jerk), .speed_cmd(speed_cmd), .ramp_cmd(ramp_cmd), .jerk_cmd(jerk_cmd),
		.rest_hold(rest_hold), .ramp_bypass(ramp_bypass), .jerk_bypass(jerk_bypass));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		n_compared++;
		if (seen !== expv)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, expv, seen);
		end
	endtask : check

	// A ratio is a Q24.8 fraction of the present command value.
	function automatic logic [31:0] scaled(input logic signed [31:0] v, input logic [31:0] r);
		logic signed [63:0] p;
		p = v * $signed(r);
		return p[RATIO_FRAC+31:RATIO_FRAC];
	endfunction : scaled

	// Read data stays put until the next read address phase, so taking it after the edge is safe.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdata = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	// The trigger bit is dropped again at once so the next trigger is a fresh rising edge.
	task automatic pulse(input int b);
		wr(CTRL_OFS, ctrl_v | (32'h1 << b));
		wr(CTRL_OFS, ctrl_v);
		repeat (3) @(posedge hclk);
	endtask : pulse

	task automatic shift(input logic [31:0] s, v, a, d, j, input logic [7:0] l);
		wr(SHIFT_OFS, s);
		wr(VEL_OFS, v);
		wr(ACC_OFS, a);
		wr(DEC_OFS, d);
		wr(JERK_OFS, j);
		wr(LEADER_OFS, {24'h0, l});
		pulse(CTRL_TRIG_BIT);
	endtask : shift

	task automatic wait_idle();
		// Busy drops one cycle before done is posted, so idle also needs done or preempted up.
		do rd(STATUS_OFS); while (rdata[ST_BUSY_BIT] !== 1'b0 || rdata[ST_DONE_BIT] === rdata[ST_PRE_BIT]);
	endtask : wait_idle

	initial
	begin
		void'($urandom(23289));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(STATUS_OFS);
		check("status reset", rdata, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			rd(SPEED_OFS + 8'(4 * i));
			check("ratio reset", rdata, RATIO_ONE);
		end
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c);
		check("unmapped", rdata, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			sync_on <= (i != 0);
			shift((i == 2) ? 32'h8000 : 32'h10, (i == 3) ? 32'h65 : ((i == 7) ? 32'hffff_fff0 : 32'h8),
				(i == 4) ? 32'h8000_0000 : 32'h0, (i == 5) ? 32'h8000_0000 : 32'h0,
				(i == 6) ? 32'h8000_0000 : 32'h0, (i == 1) ? 8'h05 : LID);
			rd(STATUS_OFS);
			check("error flag", {31'h0, rdata[ST_ERR_BIT]}, 32'h1);
			check("fault code", {16'h0, rdata[31:16]}, {16'h0, codes[i]});
		end
		exp_off = 32'sh0;
		for (int i = 0; i < 6; i++)
		begin
			amt = (i == 0) ? 32'sh7fff : $signed(32'($urandom_range(4000))) - 32'sd2000;
			shift(amt, 32'($urandom_range(64, 16)), 32'($urandom_range(8)), 32'h0, 32'h0, LID);
			wait_idle();
			check("status done", {27'h0, rdata[4:0]}, 32'h1);
			exp_off += amt;
			rd(COVERED_OFS);
			check("covered", rdata, amt);
			@(negedge hclk);
			check("leader ref", leader_ref, leader_pos - leader_vel + exp_off);
			@(posedge hclk);
		end
		enc_on <= 1'b1;
		shift(32'sd300, 32'h5, 32'h0, 32'h0, 32'h0, LID);
		@(negedge hclk);
		check("corr speed enc", corr_speed, 32'sd4 + FLIM);
		@(posedge hclk);
		wr(SHIFT_OFS, 32'h9);
		wait_idle();
		rd(COVERED_OFS);
		check("latched shift", rdata, 32'd300);
		exp_off += 32'sd300;
		enc_on <= 1'b0;
		ctrl_v = 32'h1 << CTRL_LIVE_BIT;
		shift(32'sd300, 32'h5, 32'h0, 32'h0, 32'h0, LID);
		wr(SHIFT_OFS, 32'd400);
		wait_idle();
		wr(SHIFT_OFS, 32'h7);
		rd(COVERED_OFS);
		check("live follow", rdata, 32'd400);
		exp_off += 32'sd400;
		ctrl_v = 32'h0;
		shift(32'sd600, 32'h5, 32'h0, 32'h0, 32'h0, LID);
		@(negedge hclk);
		check("corr speed", corr_speed, 32'sd9);
		@(posedge hclk);
		wr(SHIFT_OFS, 32'sd100);
		pulse(CTRL_TRIG_BIT);
		wait_idle();
		@(negedge hclk);
		// The exact offset at the retrigger edge is unknown, so only the window it must land in is checked.
		r0 = leader_ref - (leader_pos - leader_vel) - exp_off - 32'sd100;
		check("retrigger", {31'h0, (r0 > 0 && r0 < 600)}, 32'h1);
		@(posedge hclk);
		shift(32'sd1000, 32'h2, 32'h0, 32'h0, 32'h0, LID);
		wr(SHIFT_OFS, 32'h0);
		pulse(CTRL_TRIG_BIT);
		rd(STATUS_OFS);
		check("halt busy", {31'h0, rdata[ST_BUSY_BIT]}, 32'h0);
		@(negedge hclk);
		r0 = leader_ref - leader_pos;
		repeat (10) @(negedge hclk);
		check("halt hold", leader_ref - leader_pos, r0);
		@(posedge hclk);
		shift(32'sd1000, 32'h2, 32'h0, 32'h0, 32'h0, LID);
		sync_on <= 1'b0;
		wait_idle();
		check("preempted", {31'h0, rdata[ST_PRE_BIT]}, 32'h1);
		sync_on <= 1'b1;
		cur_speed <= 32'($urandom_range(20000));
		cur_ramp <= 32'($urandom_range(20000));
		cur_jerk <= 32'($urandom_range(20000));
		ctrl_v = 32'h1 << CTRL_OVR_BIT;
		wr(CTRL_OFS, ctrl_v);
		repeat (3) @(negedge hclk);
		check("speed unity", speed_cmd, cur_speed);
		check("ramp unity", ramp_cmd, cur_ramp);
		check("jerk unity", jerk_cmd, cur_jerk);
		@(posedge hclk);
		for (int i = 0; i < 3; i++)
			wr(SPEED_OFS + 8'(4 * i), 32'h0);
		repeat (3) @(negedge hclk);
		check("speed zero", speed_cmd, 32'h0);
		check("zero flags", {29'h0, rest_hold, ramp_bypass, jerk_bypass}, 32'h7);
		@(posedge hclk);
		amt = 32'($urandom_range(1023, 1));
		wr(SPEED_OFS, amt);
		repeat (3) @(negedge hclk);
		check("speed ratio", speed_cmd, scaled(cur_speed, amt));
		check("rest release", {31'h0, rest_hold}, 32'h0);
		check("response", {31'h0, hresp}, 32'h0);
		@(posedge hclk);
		ctrl_v |= 32'h1 << CTRL_MODE_BIT;
		wr(CTRL_OFS, ctrl_v);
		for (int i = 0; i < 3; i++)
		begin
			amt = 32'($urandom_range(50000, 1));
			wr(SPEED_OFS, amt);
			wr(RAMP_OFS, amt + 1);
			wr(JRAT_OFS, amt + 2);
			rd(SPDCMD_OFS);
			@(negedge hclk);
			check("abs speed", speed_cmd, amt);
			check("abs ramp", ramp_cmd, amt + 1);
			check("abs jerk", jerk_cmd, amt + 2);
			check("speed readback", rdata, amt);
			@(posedge hclk);
		end
		axis_pos <= 32'sd1000;
		axis_vel <= 32'sd50;
		stop_dist <= 32'sd200;
		for (int i = 0; i < 2; i++)
		begin
			amt = (i == 1) ? 32'sd1100 : 32'sd5000;
			wr(TARGET_OFS, amt);
			pulse(CTRL_TGT_BIT);
			@(negedge hclk);
			check("target", target_cmd, amt);
			check("reverse", {31'h0, reverse_move}, 32'(i));
			@(posedge hclk);
		end
		summarize();
	end
endmodule : tb
